/* File: rtl/adc_ctrl_pkg.sv */
// package for the converter control block: register map, field layout,
// reset values, sequencer states and carriers.
// assumes a 32-bit apb master on the system clock.
package adc_ctrl_pkg;

	// register byte addresses
	localparam logic [7:0] OFF_MODE     = 8'h00; // conv_mode_reg
	localparam logic [7:0] OFF_RES_HIGH = 8'h04; // result_high_reg
	localparam logic [7:0] OFF_RES_LOW  = 8'h08; // result_low_reg
	localparam logic [7:0] OFF_STATUS   = 8'h0C; // irq flag and busy

	// conv_mode_reg fields
	localparam int MODE_CH_LSB    = 0; // channel_select [3:0]
	localparam int MODE_START_BIT = 4; // conv_start_bit
	localparam int MODE_DONE_BIT  = 5; // conv_done_status

	// result_high_reg fields
	localparam int RH_CLK_LSB = 6; // clock source [7:6]
	localparam int RH_8BIT    = 5; // eight_bit_mode

	// status register fields
	localparam int ST_IRQ_BIT  = 0; // conv_irq_flag, write 1 to clear
	localparam int ST_BUSY_BIT = 1;

	// reset values
	localparam logic [3:0] RST_CHANNEL = 4'h0;
	localparam logic [1:0] RST_CLK_SEL = 2'h0;
	localparam logic [9:0] RST_RESULT  = 10'h000;

	// channel code that picks the internal bias reference
	localparam logic [3:0] CH_BIAS_REF = 4'hF;

	// conversion length in converter clock periods
	localparam int CONV_PERIODS = 13;
	// prescaler divide ratios (system clocks per converter clock), by select
	localparam logic [7:0] DIV_SEL0 = 8'h04;
	localparam logic [7:0] DIV_SEL1 = 8'h08;
	localparam logic [7:0] DIV_SEL2 = 8'h10;
	localparam logic [7:0] DIV_SEL3 = 8'h20;

	// recommended least converter clock period, and system clock rate
	localparam int MIN_CONV_PERIOD_NS = 1000;
	localparam int CLK_PERIOD_NS      = 40;
	localparam int MIN_CONV_CYCLES    =
		(MIN_CONV_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// sequencer states, gray along idle -> sample -> approx -> load
	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_SAMPLE = 2'b01,
		ST_APPROX = 2'b11,
		ST_LOAD   = 2'b10
	} seq_state_t;

	// analog front end command and answer
	typedef struct packed {
		logic [3:0] channel;
		logic       sample;
		logic [9:0] trial;
	} afe_req_t;

	typedef struct packed {
		logic compare;
	} afe_rsp_t;

endpackage

/* File: rtl/adc_prescaler.sv */
// converter clock tick generator: one-cycle tick every selected ratio.
// assumes the select is stable or that a change may stretch one period.
`timescale 1ns/1ps
`default_nettype none
module adc_prescaler (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// control
	input  wire logic       restart,
	input  wire logic [1:0] clk_sel,
	// tick out
	output logic            tick
);
	import adc_ctrl_pkg::*;

	logic [7:0] count;
	logic [7:0] ratio;

	// divide ratio from the select
	always_comb begin
		case (clk_sel)
			2'h0: ratio = DIV_SEL0;
			2'h1: ratio = DIV_SEL1;
			2'h2: ratio = DIV_SEL2;
			default: ratio = DIV_SEL3;
		endcase
	end

	// count up, tick on the last cycle of each period
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count <= 8'h00;
		end else if (restart || tick) begin
			count <= 8'h00;
		end else begin
			count <= count + 8'h01;
		end
	end

	assign tick = !restart && (count == ratio - 8'h01);

endmodule
`default_nettype wire

/* File: rtl/adc_conv_ctrl.sv */
// converter control: apb register slave and successive approximation
// sequencer driving the analog multiplexer, sample-and-hold and ladder.
// assumes pclk is clk, and that the comparator answer is settled each tick.
//
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - pick one channel through the mux, sample it, then approximate bit by bit
// - produce a 10-bit result split over high and low result registers
// - top two bits of the high result register select converter clock
// - four-bit channel field; code 1111b selects the internal bias reference
// - writing 1 to start bit begins conversion; hardware clears it next cycle
// - in eight-bit mode the top eight result bits go into the low register
// - on completion load results, set done bit and raise interrupt flag
// - done bit reads 0 throughout a conversion, set when it finishes
// - each conversion lasts 13 converter clock periods
module adc_conv_ctrl (
	// clock and reset
	input  wire logic                    clk,
	input  wire logic                    rst,
	// apb slave
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [7:0]              paddr,
	input  wire logic [31:0]             pwdata,
	output logic                         pready,
	output logic [31:0]                  prdata,
	output logic                         pslverr,
	// analog front end
	output adc_ctrl_pkg::afe_req_t       afe_req,
	input  wire adc_ctrl_pkg::afe_rsp_t  afe_rsp,
	// interrupt flag to the interrupt controller, and bias reference select
	output logic                         conv_irq_flag,
	output logic                         bias_ref_sel
);
	import adc_ctrl_pkg::*;

	seq_state_t state;
	seq_state_t next_state;
	logic [3:0] channel_select;
	logic       conv_start_bit;
	logic       conv_done_status;
	logic [1:0] clk_sel;
	logic       eight_bit_mode;
	logic [9:0] result;
	logic [9:0] trial;
	logic [3:0] bit_idx;
	logic [3:0] period_cnt;
	logic       tick;
	logic       wr_en;
	logic       rd_en;
	logic       start_wr;
	logic       irq_clr;
	logic       mapped;

	// apb decode; every access finishes in its first access cycle
	assign pready  = 1'b1;
	assign wr_en   = psel && penable && pwrite;
	assign rd_en   = psel && penable && !pwrite;
	assign mapped  = (paddr == OFF_MODE) || (paddr == OFF_RES_HIGH) ||
		(paddr == OFF_RES_LOW) || (paddr == OFF_STATUS);
	assign pslverr = psel && penable && !mapped;
	assign start_wr = wr_en && (paddr == OFF_MODE) &&
		pwdata[MODE_START_BIT];
	assign irq_clr = wr_en && (paddr == OFF_STATUS) && pwdata[ST_IRQ_BIT];

	// converter clock ticks
	adc_prescaler u_presc (
		.clk     (clk),
		.rst     (rst),
		.restart (start_wr),
		.clk_sel (clk_sel),
		.tick    (tick)
	);

	// software-written control fields
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			channel_select <= RST_CHANNEL;
			clk_sel        <= RST_CLK_SEL;
			eight_bit_mode <= 1'b0;
		end else if (wr_en && paddr == OFF_MODE) begin
			channel_select <= pwdata[MODE_CH_LSB +: 4];
		end else if (wr_en && paddr == OFF_RES_HIGH) begin
			clk_sel        <= pwdata[RH_CLK_LSB +: 2];
			eight_bit_mode <= pwdata[RH_8BIT];
		end
	end

	// self-clearing start bit
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			conv_start_bit <= 1'b0;
		end else begin
			conv_start_bit <= start_wr;
		end
	end

	// sequencer next state
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE:   next_state = ST_IDLE;
			ST_SAMPLE: if (tick && period_cnt == 4'd1) next_state = ST_APPROX;
			ST_APPROX: if (tick && bit_idx == 4'd0) next_state = ST_LOAD;
			ST_LOAD:   if (tick) next_state = ST_IDLE;
			default:   next_state = ST_IDLE;
		endcase
		if (start_wr) begin
			next_state = ST_SAMPLE;
		end
	end

	// sequencer: 2 sample periods, 10 bit periods, 1 load period
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state      <= ST_IDLE;
			period_cnt <= 4'd0;
			bit_idx    <= 4'd9;
			trial      <= 10'h000;
		end else begin
			state <= next_state;
			if (start_wr) begin
				period_cnt <= 4'd0;
				bit_idx    <= 4'd9;
				trial      <= 10'h200;
			end else if (tick && state != ST_IDLE) begin
				period_cnt <= period_cnt + 4'd1;
				if (state == ST_APPROX) begin
					// keep or drop the trial bit, try the next
					if (!afe_rsp.compare) begin
						trial[bit_idx] <= 1'b0;
					end
					if (bit_idx != 4'd0) begin
						trial[bit_idx - 4'd1] <= 1'b1;
						bit_idx <= bit_idx - 4'd1;
					end
				end
			end
		end
	end

	// result load and done status; result kept until the next completion, done bit cleared by a start
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			result           <= RST_RESULT;
			conv_done_status <= 1'b1;
		end else if (start_wr) begin
			conv_done_status <= 1'b0;
		end else if (state == ST_LOAD && tick) begin
			result           <= trial;
			conv_done_status <= 1'b1;
		end
	end

	// interrupt request flag; the set wins over a clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			conv_irq_flag <= 1'b0;
		end else if (state == ST_LOAD && tick && !start_wr) begin
			conv_irq_flag <= 1'b1;
		end else if (irq_clr) begin
			conv_irq_flag <= 1'b0;
		end
	end

	// analog front end drive
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			afe_req <= '0;
		end else begin
			afe_req.channel <= channel_select;
			afe_req.sample  <= (next_state == ST_SAMPLE);
			afe_req.trial   <= trial;
		end
	end
	assign bias_ref_sel = (afe_req.channel == CH_BIAS_REF);

	// read data, registered; eight-bit mode packs the top bits low
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			case (paddr)
				OFF_MODE: prdata <= {26'h0, conv_done_status,
					conv_start_bit, channel_select};
				OFF_RES_HIGH: prdata <= {24'h0, clk_sel, eight_bit_mode,
					3'h0, eight_bit_mode ? 2'h0 : result[9:8]};
				OFF_RES_LOW: prdata <= {24'h0, eight_bit_mode ?
					result[9:2] : result[7:0]};
				OFF_STATUS: prdata <= {30'h0, state != ST_IDLE,
					conv_irq_flag};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	// checks
	sequence s_start;
		start_wr;
	endsequence

	a_start_clears: assert property (@(posedge clk) disable iff (rst)
		s_start |=> conv_start_bit ##1 (!conv_start_bit || $past(start_wr)))
		else $error("start bit did not self clear");
	a_done_low_busy: assert property (@(posedge clk) disable iff (rst)
		(state != ST_IDLE && state != ST_LOAD) |-> !conv_done_status)
		else $error("done bit high during conversion");
	a_load_sets_done: assert property (@(posedge clk) disable iff (rst)
		(state == ST_LOAD && tick && !start_wr) |=>
		(conv_done_status && conv_irq_flag && result == $past(trial)))
		else $error("completion did not load and flag");
	a_result_holds: assert property (@(posedge clk) disable iff (rst)
		!(state == ST_LOAD && tick) |=> $stable(result))
		else $error("result changed without completion");
	a_restart_seq: assert property (@(posedge clk) disable iff (rst)
		s_start |=> (state == ST_SAMPLE && period_cnt == 4'd0))
		else $error("start did not restart sequence");
	a_period_count: assert property (@(posedge clk) disable iff (rst)
		(state == ST_LOAD && tick) |-> period_cnt == 4'(CONV_PERIODS - 1))
		else $error("conversion length not thirteen periods");
	a_eight_bit: assert property (@(posedge clk) disable iff (rst)
		(psel && !penable && !pwrite && paddr == OFF_RES_LOW &&
		eight_bit_mode) |=> prdata[7:0] == $past(result[9:2]))
		else $error("eight bit result misplaced");
	a_bias_sel: assert property (@(posedge clk) disable iff (rst)
		bias_ref_sel == ($past(channel_select) == CH_BIAS_REF))
		else $error("bias reference select wrong");
	a_clk_field: assert property (@(posedge clk) disable iff (rst)
		(wr_en && paddr == OFF_RES_HIGH) |=> clk_sel == $past(pwdata[7:6]))
		else $error("clock select not written");
	a_mux_follow: assert property (@(posedge clk) disable iff (rst)
		$changed(channel_select) |=> afe_req.channel == $past(channel_select))
		else $error("mux channel not applied");
	a_ten_bits: assert property (@(posedge clk) disable iff (rst)
		(psel && !penable && !pwrite && paddr == OFF_RES_HIGH &&
		!eight_bit_mode) |=> prdata[1:0] == $past(result[9:8]))
		else $error("high result bits wrong");

endmodule
`default_nettype wire

/* File: test/analog_src.sv */
// analog source model: one fixed level per channel and a comparator.
// assumes afe_req comes from the converter control block on clk.
`timescale 1ns/1ps
`default_nettype none
module analog_src (
	// clock and reset
	input  wire logic                    clk,
	input  wire logic                    rst,
	// brownout control bars that gate the bias reference
	input  wire logic                    brownout_enable_n,
	input  wire logic                    bias_ref_select_n,
	// converter side
	input  wire adc_ctrl_pkg::afe_req_t  req,
	output var adc_ctrl_pkg::afe_rsp_t   rsp
);
	import adc_ctrl_pkg::*;
	logic [9:0] held;
	// hold the selected input while the sample strobe is high;
	// the bias reference stays dead unless both bars are cleared
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			held <= 10'h000;
		end else if (req.sample) begin
			if (req.channel == CH_BIAS_REF &&
				(brownout_enable_n || bias_ref_select_n)) begin
				held <= 10'h000;
			end else begin
				held <= {req.channel, 6'h2B};
			end
		end
	end
	// comparator: held level against the ladder trial
	assign rsp.compare = held >= req.trial;
endmodule
`default_nettype wire

/* File: test/adc_conversion_control_tb.sv */
// testbench for the converter control block: apb tasks, conversions.
// assumes the analog source model and the design package.
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_control_tb;
	import adc_ctrl_pkg::*;
	localparam logic [7:0] OFF_NONE = 8'h10;
	logic        clk, rst, psel, penable, pwrite, pready, pslverr;
	logic        irq, bias, slv;
	logic        brownout_enable_n, bias_ref_select_n;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	afe_req_t    req;
	afe_rsp_t    rsp;
	int          err_count, n_checks, cyc, n;
	logic [9:0]  lvl;
	logic [7:0]  dv [4];

	adc_conv_ctrl DUT (.clk(clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .afe_req(req), .afe_rsp(rsp),
		.conv_irq_flag(irq), .bias_ref_sel(bias));
	analog_src src (.clk(clk), .rst(rst),
		.brownout_enable_n(brownout_enable_n),
		.bias_ref_select_n(bias_ref_select_n),
		.req(req), .rsp(rsp));

	// clock and cycle count
	initial begin
		clk = 1'h0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) cyc <= cyc + 1;

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// one apb transfer, held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		// wait for the answer; only the watchdog ends a hang
		do begin
			@(posedge clk);
		end while (pready !== 1'h1);
		rd = prdata;
		slv = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clk);
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'h0, a, 32'h0);
		chk(rd, exp);
	endtask

	// start a conversion and time it up to the done bit
	task automatic conv(input logic [3:0] ch, input int d);
		int t0;
		apb(1'h1, OFF_MODE, {27'h0, 1'h1, ch});
		t0 = cyc;
		apb(1'h0, OFF_MODE, 32'h0);
		chk(rd & 32'h2F, {28'h0, ch});
		chk(32'(bias), 32'(ch == CH_BIAS_REF));
		while (rd[MODE_DONE_BIT] !== 1'h1 && cyc - t0 < 2000) begin
			apb(1'h0, OFF_MODE, 32'h0);
		end
		n = cyc - t0;
		chk(rd, {26'h0, 2'h2, ch});
		// poll spacing of three cycles puts n at 13 periods plus 2..4
		chk(32'(n >= CONV_PERIODS * d + 1), 32'h1);
		chk(32'(n <= CONV_PERIODS * d + 5), 32'h1);
		chk(32'(irq), 32'h1);
		lvl = {ch, 6'h2B};
	endtask

	// result registers in 10-bit or 8-bit layout
	task automatic results(input logic e8, input logic [1:0] s);
		rdchk(OFF_RES_HIGH, {24'h0, s, e8, 3'h0,
			e8 ? 2'h0 : lvl[9:8]});
		rdchk(OFF_RES_LOW, {24'h0,
			e8 ? lvl[9:2] : lvl[7:0]});
	endtask

	task automatic tally_and_finish;
		$display("checks=%0d errors=%0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// watchdog
	initial begin
		#(40 * 8000);
		err_count++;
		tally_and_finish;
	end

	// main sequence
	initial begin
		dv = '{DIV_SEL0, DIV_SEL1, DIV_SEL2, DIV_SEL3};
		{rst, psel, penable, pwrite} = 4'h8;
		{brownout_enable_n, bias_ref_select_n} = 2'h3;
		paddr = 8'h00;
		pwdata = 32'h0;
		err_count = 0;
		n_checks = 0;
		repeat (12) @(posedge clk);
		rst <= 1'h0;
		@(posedge clk);
		rdchk(OFF_MODE, 32'h20);
		rdchk(OFF_RES_HIGH, 32'h0);
		rdchk(OFF_RES_LOW, 32'h0);
		rdchk(OFF_STATUS, 32'h0);
		rdchk(OFF_NONE, 32'h0);
		chk(32'(slv), 32'h1);
		// clear both brownout bars before the bias channel is used
		brownout_enable_n <= 1'h0;
		bias_ref_select_n <= 1'h0;
		// every clock select, alternating result layout, bias channel last
		for (int s = 0; s < 4; s++) begin
			apb(1'h1, OFF_RES_HIGH, {24'h0, 2'(s), s[0], 5'h0});
			conv(4'(12 + s), int'(dv[s]));
			results(s[0], 2'(s));
			apb(1'h1, OFF_STATUS, 32'h1);
			chk(32'(irq), 32'h0);
		end
		// restart in mid-run; old result stays until the new one lands
		apb(1'h1, OFF_MODE, 32'h15);
		repeat (100) @(posedge clk);
		rdchk(OFF_RES_LOW, {24'h0, lvl[9:2]});
		rdchk(OFF_MODE, 32'h05);
		rdchk(OFF_STATUS, 32'h2);
		conv(4'h5, int'(DIV_SEL3));
		results(1'h1, 2'h3);
		tally_and_finish;
	end
endmodule
`default_nettype wire
